// ==== crcd_decoder.sv ====
// Control command word decoder: one 16-bit command per write strobe, one-cycle action pulses.
// Assumes the write strobe and word are synchronous to ref_clk and the device type straps are static.
`timescale 1ns/1ps
`default_nettype none
`include "crcd_regs.svh"

// Functional notes
// - The command word is selector in the upper byte and argument in the lower byte.
// - Selector 0x12 with zero argument forces outputs to default only when host-link-failure is enabled.
// - Selector 0x13 samples each enabled input whose mask bit is set, bit 0 being input 1.
// - Selector 0x20 on a gateway with no survey running starts a survey with node 1 to 0x38 given in the argument.
// - While a survey runs the gateway suppresses its error reporting.
// - Selector 0x20 with argument zero ends any running survey.
// - Selector 0x30 sets all switched supplies to the argument voltage code (off,5,7,15,20,24 V).
// - Selectors 0x31 to 0x34 set switched supply 1 to 4 with the same code.
// - Selector 0x10 with zero argument starts baseline on a magnetic-sensing node.
module crcd_decoder
  import crcd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        cmd_wr,
  input  wire logic [15:0] cmd_word,
  input  wire logic        is_gateway,
  input  wire logic        has_switched_pwr,
  input  wire logic        is_mag_node,
  input  wire logic        host_fail_en,
  input  wire logic [5:0]  input_enabled,
  input  wire logic        err_report_in,
  output logic             force_default,
  output logic [5:0]       sample_req,
  output logic             baseline_start,
  output logic             survey_active,
  output logic [7:0]       survey_node,
  output logic             err_report_out,
  output logic [7:0]       pwr_code_1,
  output logic [7:0]       pwr_code_2,
  output logic [7:0]       pwr_code_3,
  output logic [7:0]       pwr_code_4
);

  crcd_state_t st;
  crcd_state_t next_st;
  logic [7:0]  sel;
  logic [7:0]  arg;

  // Only listed voltage codes are taken; anything else leaves the supply as it was
  function automatic logic volt_ok(input logic [7:0] c);
    volt_ok = (c == `CRCD_V_OFF) || (c == `CRCD_V_5) || (c == `CRCD_V_7) ||
              (c == `CRCD_V_15) || (c == `CRCD_V_20) || (c == `CRCD_V_24);
  endfunction : volt_ok

  assign sel = cmd_word[15:`CRCD_SEL_LSB];
  assign arg = cmd_word[`CRCD_SEL_LSB-1:0];

  always_comb
  begin
    next_st            = st;
    next_st.force_dflt = 1'b0;
    next_st.sample_req = 6'h00;
    next_st.baseline   = 1'b0;
    if (cmd_wr)
    begin
      case (sel)
        `CRCD_SEL_HOST_TO:
        begin
          if (arg == 8'h00 && host_fail_en)
            next_st.force_dflt = 1'b1;
        end
        `CRCD_SEL_SAMPLE:
          next_st.sample_req = arg[5:0] & input_enabled;
        `CRCD_SEL_SURVEY:
        begin
          if (is_gateway)
          begin
            if (arg == 8'h00)
            begin
              next_st.survey_on   = 1'b0;
              next_st.survey_node = 8'h00;
            end
            // A second start while running is refused; the host must end the first
            else if (arg <= `CRCD_NODE_MAX && !st.survey_on)
            begin
              next_st.survey_on   = 1'b1;
              next_st.survey_node = arg;
            end
          end
        end
        `CRCD_SEL_PWR_ALL:
        begin
          if (has_switched_pwr && volt_ok(arg))
            next_st.pwr_code = {4{arg}};
        end
        `CRCD_SEL_BASELINE:
        begin
          if (arg == 8'h00 && is_mag_node)
            next_st.baseline = 1'b1;
        end
        default:
        begin
          if (sel >= `CRCD_SEL_PWR_FIRST && sel <= `CRCD_SEL_PWR_LAST && has_switched_pwr && volt_ok(arg))
            next_st.pwr_code[2'(sel - `CRCD_SEL_PWR_FIRST)] = arg;
          // Every other selector falls through with the state left as it was
        end
      endcase
    end
  end

  // One register for the whole state, so reset clears every output except err_report_out on the same edge
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign force_default  = st.force_dflt;
  assign sample_req     = st.sample_req;
  assign baseline_start = st.baseline;
  assign survey_active  = st.survey_on;
  assign survey_node    = st.survey_node;
  // Gated after the register, so muting starts on the very edge that starts a survey
  assign err_report_out = err_report_in & ~st.survey_on;
  assign pwr_code_1     = st.pwr_code[0];
  assign pwr_code_2     = st.pwr_code[1];
  assign pwr_code_3     = st.pwr_code[2];
  assign pwr_code_4     = st.pwr_code[3];

  sequence s_survey_start;
    cmd_wr && is_gateway && sel == `CRCD_SEL_SURVEY && arg != 8'h00 && arg <= `CRCD_NODE_MAX && !survey_active;
  endsequence

  sequence s_survey_stop;
    cmd_wr && is_gateway && sel == `CRCD_SEL_SURVEY && arg == 8'h00;
  endsequence

  sequence s_pwr_bad_code;
    cmd_wr && has_switched_pwr && sel >= `CRCD_SEL_PWR_ALL && sel <= `CRCD_SEL_PWR_LAST && !volt_ok(arg);
  endsequence

  chk_host_timeout_force: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && cmd_word == 16'h1200 && host_fail_en) |=> force_default)
    else $error("Host timeout did not force defaults");
  chk_force_needs_enable: assert property (@(posedge ref_clk) disable iff (!arst_n)
    force_default |-> $past(cmd_wr) && $past(host_fail_en) && $past(cmd_word) == 16'h1200)
    else $error("Defaults forced without cause");
  chk_sample_mask_map: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && sel == `CRCD_SEL_SAMPLE) |=> sample_req == ($past(arg[5:0]) & $past(input_enabled)))
    else $error("Sample request mask wrong");
  chk_survey_start_node: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_survey_start |=> survey_active && survey_node == $past(arg))
    else $error("Survey did not start");
  chk_survey_mutes_err: assert property (@(posedge ref_clk) disable iff (!arst_n)
    survey_active |-> !err_report_out)
    else $error("Error reported during survey");
  chk_survey_stop_ends: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_survey_stop |=> !survey_active && survey_node == 8'h00 && err_report_out == err_report_in)
    else $error("Survey did not end");
  chk_pwr_all_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && sel == `CRCD_SEL_PWR_ALL && has_switched_pwr && arg == `CRCD_V_24) |=>
    pwr_code_1 == `CRCD_V_24 && pwr_code_4 == `CRCD_V_24)
    else $error("All supplies not set");
  chk_pwr_single_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && sel == 8'h33 && has_switched_pwr && volt_ok(arg)) |=>
    pwr_code_3 == $past(arg) && $stable(pwr_code_1))
    else $error("Single supply not set");
  chk_baseline_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && cmd_word == 16'h1000 && is_mag_node) |=> baseline_start ##1 (!baseline_start || $past(cmd_wr)))
    else $error("Baseline pulse wrong");
  chk_unknown_ignored: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && sel == 8'h77) |=> $stable(survey_active) && $stable(pwr_code_2) && sample_req == 6'h00)
    else $error("Undefined selector changed state");

  // Refused commands must leave the state exactly as it was
  chk_timeout_refused: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && sel == `CRCD_SEL_HOST_TO && (arg != 8'h00 || !host_fail_en)) |=> !force_default)
    else $error("Defaults forced by a refused timeout command");
  chk_baseline_refused: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && sel == `CRCD_SEL_BASELINE && (arg != 8'h00 || !is_mag_node)) |=> !baseline_start)
    else $error("Baseline started by a refused command");
  chk_survey_gateway_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && !is_gateway) |=> $stable(survey_active) && $stable(survey_node))
    else $error("Survey state changed on a non-gateway device");
  chk_survey_range_refused: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && sel == `CRCD_SEL_SURVEY && arg > `CRCD_NODE_MAX) |=>
    $stable(survey_active) && $stable(survey_node))
    else $error("Survey changed for a node out of range");
  chk_survey_busy_refused: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && sel == `CRCD_SEL_SURVEY && arg != 8'h00 && survey_active) |=> survey_active && $stable(survey_node))
    else $error("Second survey started while one was running");
  chk_pwr_bad_refused: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_pwr_bad_code |=> $stable(pwr_code_1) && $stable(pwr_code_2) && $stable(pwr_code_3) && $stable(pwr_code_4))
    else $error("Supply changed by an unlisted voltage code");
  chk_pwr_needs_strap: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && !has_switched_pwr) |=>
    $stable(pwr_code_1) && $stable(pwr_code_2) && $stable(pwr_code_3) && $stable(pwr_code_4))
    else $error("Supply changed on a device without switched supplies");

  // Invariants and the remaining positive cases
  chk_baseline_needs_cause: assert property (@(posedge ref_clk) disable iff (!arst_n)
    baseline_start |-> $past(cmd_wr) && $past(is_mag_node) && $past(cmd_word) == 16'h1000)
    else $error("Baseline pulse without its command");
  chk_pulse_needs_strobe: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !cmd_wr |=> sample_req == 6'h00 && !force_default && !baseline_start)
    else $error("Action pulse without a write strobe");
  chk_err_passes_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !survey_active |-> err_report_out == err_report_in)
    else $error("Error report blocked with no survey running");
  chk_survey_idle_node: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !survey_active |-> survey_node == 8'h00)
    else $error("Survey node left over after the survey ended");
  chk_pwr_all_any: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && sel == `CRCD_SEL_PWR_ALL && has_switched_pwr && volt_ok(arg)) |=>
    pwr_code_1 == $past(arg) && pwr_code_2 == $past(arg) && pwr_code_3 == $past(arg) && pwr_code_4 == $past(arg))
    else $error("All supplies not set to the code");
  chk_pwr_first_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && sel == `CRCD_SEL_PWR_FIRST && has_switched_pwr && volt_ok(arg)) |=>
    pwr_code_1 == $past(arg) && $stable(pwr_code_2) && $stable(pwr_code_3) && $stable(pwr_code_4))
    else $error("First supply not set alone");
  chk_pwr_last_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_wr && sel == `CRCD_SEL_PWR_LAST && has_switched_pwr && volt_ok(arg)) |=>
    pwr_code_4 == $past(arg) && $stable(pwr_code_1))
    else $error("Last supply not set");

endmodule : crcd_decoder
`default_nettype wire

// ==== crcd_decoder_tb.sv ====
// Self-checking bench for the command decoder, driven through the host model.
// Assumes device straps stay static while a command is decoded.
`timescale 1ns/1ps
`default_nettype none
module crcd_decoder_tb import crcd_pkg::*; ;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cmd_wr, mag = 1'b1, hf = 1'b0, fd, base, sact, err_out, gw = 1'b1, swp = 1'b1, err_in = 1'b1;
  logic [15:0] cmd_word;
  logic [5:0]  in_en = 6'h0F, smp;
  logic [7:0]  snode, p1, p2, p3, p4;
  logic [7:0]  codes [6] = '{8'h00, 8'h05, 8'h07, 8'h0F, 8'h14, 8'h18};
  int          n_errors = 0;
  int          n_tests = 0;
  always #2 ref_clk = ~ref_clk;
  crcd_host_model i_host (.ref_clk(ref_clk), .cmd_wr(cmd_wr), .cmd_word(cmd_word));
  crcd_decoder i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_wr(cmd_wr), .cmd_word(cmd_word),
    .is_gateway(gw), .has_switched_pwr(swp), .is_mag_node(mag), .host_fail_en(hf),
    .input_enabled(in_en), .err_report_in(err_in), .force_default(fd), .sample_req(smp),
    .baseline_start(base), .survey_active(sact), .survey_node(snode), .err_report_out(err_out),
    .pwr_code_1(p1), .pwr_code_2(p2), .pwr_code_3(p3), .pwr_code_4(p4));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [15:0] w);
    i_host.write_reg(31, w);
  endtask : wr
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  initial
  begin
    #2000;
    n_errors++;
    test_done();
  end
  initial
  begin
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    chk("pwr_rst", {p1, p2, p3, p4}, 32'h00000000);
    wr(16'h1200);
    chk("dflt_off", fd, 32'h0);
    hf = 1'b1;
    wr(16'h1200);
    chk("dflt_on", fd, 32'h1);
    wr(16'h1201);
    chk("dflt_arg", fd, 32'h0);
    $display("test host timeout done");
    wr(16'h133F);
    chk("sample", smp, 32'h0F);
    @(negedge ref_clk);
    chk("sample_end", smp, 32'h00);
    in_en = 6'h3F;
    wr(16'h1322);
    chk("sample_mask", smp, 32'h22);
    $display("test sample done");
    err_in = 1'b0;
    @(negedge ref_clk);
    chk("err_idle", err_out, 32'h0);
    err_in = 1'b1;
    wr(16'h2039);
    chk("svy_range", sact, 32'h0);
    wr(16'h2038);
    chk("svy_max", {sact, snode}, 32'h138);
    chk("err_mask", err_out, 32'h0);
    i_host.send(16'h2010);
    chk("svy_busy", {sact, snode}, 32'h138);
    wr(16'h2005);
    chk("svy_next", {sact, snode}, 32'h105);
    wr(16'h2000);
    chk("svy_stop", {sact, snode, err_out}, 32'h001);
    gw = 1'b0;
    wr(16'h2010);
    chk("svy_gw", {sact, snode}, 32'h000);
    $display("test survey done");
    foreach (codes[i])
    begin
      wr({8'h30, codes[i]});
      chk("pwr_all", {p1, p2, p3, p4}, {4{codes[i]}});
    end
    for (int i = 0; i < 4; i++)
    begin
      wr({8'h31 + 8'(i), 8'h07});
      chk("pwr_one", ({p1, p2, p3, p4} >> (24 - 8 * i)) & 32'h000000FF, 32'h07);
    end
    wr(16'h3009);
    wr(16'h7700);
    chk("pwr_bad", {p1, p2, p3, p4}, 32'h07070707);
    swp = 1'b0;
    wr(16'h3005);
    chk("pwr_strap", {p1, p2, p3, p4}, 32'h07070707);
    $display("test power done");
    wr(16'h1000);
    chk("base_on", base, 32'h1);
    wr(16'h1001);
    chk("base_arg", base, 32'h0);
    mag = 1'b0;
    wr(16'h1000);
    chk("base_strap", base, 32'h0);
    $display("test baseline done");
    test_done();
  end
endmodule : crcd_decoder_tb
`default_nettype wire

// ==== crcd_host_model.sv ====
// Host controller model: writes command words into a node's command register.
// Assumes the bench calls write_reg from one process only.
`timescale 1ns/1ps
`default_nettype none
module crcd_host_model
(
  input  wire logic        ref_clk,
  output logic             cmd_wr,
  output logic [15:0]      cmd_word
);
  logic [7:0] open_node = 8'h00;
  initial cmd_wr = 1'b0;
  initial cmd_word = 16'hFFFF;
  task automatic send(input logic [15:0] w);
    @(negedge ref_clk);
    cmd_wr = 1'b1;
    cmd_word = w;
    @(negedge ref_clk);
    cmd_wr = 1'b0;
    // Word is not held after the strobe, so a stale value cannot pass for a new one
    cmd_word = ~w;
  endtask : send
  task automatic write_reg(input int host_reg, input logic [15:0] w);
    if (host_reg != 31) return;
    if (w[15:8] == 8'h20 && w[7:0] != 8'h00 && open_node != 8'h00 && open_node != w[7:0])
      send(16'h2000);
    if (w[15:8] == 8'h20)
      open_node = w[7:0];
    send(w);
  endtask : write_reg
endmodule : crcd_host_model
`default_nettype wire

// ==== crcd_pkg.sv ====
// Types shared by the control command decoder.
// Assumes crcd_regs.svh is on the include path.
`include "crcd_regs.svh"
package crcd_pkg;
  typedef struct packed {
    logic [7:0]       survey_node;
    logic             survey_on;
    logic [3:0][7:0]  pwr_code;
    logic             force_dflt;
    logic [5:0]       sample_req;
    logic             baseline;
  } crcd_state_t;
endpackage : crcd_pkg

// ==== crcd_regs.svh ====
// Constants for the control command decoder: selector codes, argument limits, voltage codes.
// Assumes inclusion by the package and the decoder only.
`ifndef CRCD_REGS_SVH
`define CRCD_REGS_SVH
`define CRCD_SEL_BASELINE  8'h10
`define CRCD_SEL_HOST_TO   8'h12
`define CRCD_SEL_SAMPLE    8'h13
`define CRCD_SEL_SURVEY    8'h20
`define CRCD_SEL_PWR_ALL   8'h30
`define CRCD_SEL_PWR_FIRST 8'h31
`define CRCD_SEL_PWR_LAST  8'h34
`define CRCD_NODE_MAX      8'h38
`define CRCD_INPUT_MASK    8'h3F
`define CRCD_V_OFF         8'h00
`define CRCD_V_5           8'h05
`define CRCD_V_7           8'h07
`define CRCD_V_15          8'h0F
`define CRCD_V_20          8'h14
`define CRCD_V_24          8'h18
`define CRCD_SEL_LSB       8
`define CRCD_PWR_RESET     8'h00
`endif
